// ### src/ffse_consts.vh
// constants for the flash fault, status and channel enable register bank
// included by ffse_regs.v only; holds definitions, no logic
`ifndef FFSE_CONSTS_VH
`define FFSE_CONSTS_VH

// register offsets on the serial bus
`define FFSE_OFS_FAULT     8'h0c
`define FFSE_OFS_CAP1      8'h0d
`define FFSE_OFS_CAP2      8'h0e
`define FFSE_OFS_ENABLE    8'h0f

// fault register bit positions
`define FFSE_B_OVP         7
`define FFSE_B_SC          6
`define FFSE_B_OT          5
`define FFSE_B_TO          4
`define FFSE_B_TX          3
`define FFSE_B_LOWBAT      2
`define FFSE_B_IPEAK       1
`define FFSE_B_IDC         0

// enable register bit positions
`define FFSE_B_CHAN2       1
`define FFSE_B_CHAN1       0

// capture field width and reserved top bits
`define FFSE_CODE_W        6
`define FFSE_CAP_RSVD      2'h0

// reset values, unmapped read value and pointer step
`define FFSE_RST_FAULT     8'h00
`define FFSE_RST_CODE      6'h00
`define FFSE_RST_ENABLE    8'h00
`define FFSE_RD_UNMAPPED   8'h00
`define FFSE_RST_BYTE      8'h00
`define FFSE_RST_SHIFT     7'h00
`define FFSE_PTR_STEP      8'h01

// serial bit counting
`define FFSE_CNT_LAST      4'h7
`define FFSE_CNT_BYTE      4'h8
`define FFSE_CNT_ZERO      4'h0
`define FFSE_CNT_ONE       4'h1

`endif

// ### src/ffse_regs.v
// register bank for fault status, dc limit current capture and channel enable,
// reached over an i2c-compatible slave port sampled on MCLK.
// assumes SCL_IN/SDA_IN are synchronous to MCLK and far slower than it,
// and that detector inputs are levels from analog logic outside.
// assumes the host holds SCL high and low for two MCLK periods or more,
// and that the enable outputs go straight to the current source gates.
`timescale 1ns/10ps
`include "ffse_consts.vh"
`default_nettype none

module ffse_regs #(
	parameter [6:0] DEV_ADDR = 7'h2a  // arbitrary neutral slave address
) (
	input  wire                    MCLK,
	input  wire                    RST_N,
	// serial bus lines, sampled on MCLK
	input  wire                    SCL_IN,
	input  wire                    SDA_IN,
	output wire                    SDA_OUT,
	output wire                    SDA_OE,
	// detector levels from the analog side
	input  wire                    OVP_DET,
	input  wire                    SHORT_DET,
	input  wire                    OVERTEMP_DET,
	input  wire                    TIMEOUT_DET,
	input  wire                    FLASH_ACTIVE,
	input  wire                    TRANSMITTER_REDUCTION_INPUT_IN,
	input  wire                    LOWBAT_DET,
	input  wire                    LOWBAT_DET_EN,
	input  wire                    IPEAK_DET,
	input  wire                    DC_LIMIT_DET,
	input  wire                    DC_LIMIT_EN,
	// flash current codes of the two channels
	input  wire [`FFSE_CODE_W-1:0] LED1_FLASH_CODE,
	input  wire [`FFSE_CODE_W-1:0] LED2_FLASH_CODE,
	// channel enables to the current sources
	output wire                    CHAN1_ON,
	output wire                    CHAN2_ON
);

	// one-hot serial states
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_REG  = 7'h04;
	localparam [6:0] ST_WR   = 7'h08;
	localparam [6:0] ST_ACK  = 7'h10;
	localparam [6:0] ST_RD   = 7'h20;
	localparam [6:0] ST_RACK = 7'h40;

	// register contents and detector history
	reg  [7:0]              fault_status_r;
	reg  [`FFSE_CODE_W-1:0] led1_captured_current_r;
	reg  [`FFSE_CODE_W-1:0] led2_captured_current_r;
	reg  [7:0]              led_channel_enable_r;
	reg                     tx_reduction_seen_r;
	reg                     flash_q_r;
	reg                     dc_q_r;
	// serial engine
	reg                     scl_q_r;
	reg                     sda_q_r;
	reg  [6:0]              state_r;
	reg  [6:0]              after_ack_r;
	reg                     ack_on_r;
	reg  [3:0]              cnt_r;
	reg  [6:0]              rx_r;
	reg  [7:0]              tx_r;
	reg  [7:0]              ptr_r;
	reg                     sda_oe_r;
	reg                     sda_out_r;

	// decode and gating
	wire                    dc_limit_reached;
	wire                    low_battery_flag;
	wire                    scl_rise;
	wire                    scl_fall;
	wire                    bus_start;
	wire                    bus_stop;
	wire [7:0]              rx_byte;
	wire                    chan1_on;
	wire                    chan2_on;
	wire                    en_write_ok;

	// read multiplexer, used for first byte and for each auto-increment
	// unmapped offsets read zero so a stray pointer returns nothing stale
	function [7:0] rd_mux;
		input [7:0] ofs;
		begin
			case (ofs)
				`FFSE_OFS_FAULT:  rd_mux = fault_status_r;
				`FFSE_OFS_CAP1:   rd_mux = {`FFSE_CAP_RSVD, led1_captured_current_r};
				`FFSE_OFS_CAP2:   rd_mux = {`FFSE_CAP_RSVD, led2_captured_current_r};
				`FFSE_OFS_ENABLE: rd_mux = led_channel_enable_r;
				default:          rd_mux = `FFSE_RD_UNMAPPED;
			endcase
		end
	endfunction

	// detector gating: these flags only mean something while enabled
	// with detection off the bit reads zero
	assign low_battery_flag = LOWBAT_DET & LOWBAT_DET_EN;
	assign dc_limit_reached = DC_LIMIT_DET & DC_LIMIT_EN;

	// bus edge and condition detection on the sampled lines
	// start and stop need scl high in both samples, so a data change
	// made while scl is low never reads as a bus condition
	assign scl_rise  = SCL_IN & ~scl_q_r;
	assign scl_fall  = ~SCL_IN & scl_q_r;
	assign bus_start = SCL_IN & scl_q_r & sda_q_r & ~SDA_IN;
	assign bus_stop  = SCL_IN & scl_q_r & ~sda_q_r & SDA_IN;
	assign rx_byte   = {rx_r, SDA_IN};

	// channel outputs are the two low enable bits
	assign chan1_on = led_channel_enable_r[`FFSE_B_CHAN1];
	assign chan2_on = led_channel_enable_r[`FFSE_B_CHAN2];

	// a one-sided set while the other channel runs would start a
	// staggered flash the boost cannot ramp for; the whole byte is dropped
	// clearing is always accepted, whichever channel is on
	assign en_write_ok =
		~(rx_byte[`FFSE_B_CHAN2] & ~chan2_on & chan1_on) &
		~(rx_byte[`FFSE_B_CHAN1] & ~chan1_on & chan2_on);

	// fault register follows the detectors; host writes never reach it
	// live levels, one cycle late, except the tx bit, which holds until the next flash start; nothing is cleared on read
	always @(posedge MCLK) begin
		if (!RST_N) begin
			fault_status_r <= `FFSE_RST_FAULT;
		end else begin
			fault_status_r[`FFSE_B_OVP]    <= OVP_DET;
			fault_status_r[`FFSE_B_SC]     <= SHORT_DET;
			fault_status_r[`FFSE_B_OT]     <= OVERTEMP_DET;
			fault_status_r[`FFSE_B_TO]     <= TIMEOUT_DET;
			fault_status_r[`FFSE_B_TX]     <= tx_reduction_seen_r;
			fault_status_r[`FFSE_B_LOWBAT] <= low_battery_flag;
			fault_status_r[`FFSE_B_IPEAK]  <= IPEAK_DET;
			fault_status_r[`FFSE_B_IDC]    <= dc_limit_reached;
		end
	end

	// tx reduction memory: cleared at each flash start, set wins over clear
	// holds after the flash ends so the host can read it afterwards
	// a flash start with the mask already active ends set
	always @(posedge MCLK) begin
		if (!RST_N) begin
			tx_reduction_seen_r <= 1'b0;
			flash_q_r           <= 1'b0;
		end else begin
			flash_q_r <= FLASH_ACTIVE;
			if (FLASH_ACTIVE & TRANSMITTER_REDUCTION_INPUT_IN) begin
				tx_reduction_seen_r <= 1'b1;
			end else if (FLASH_ACTIVE & ~flash_q_r) begin
				tx_reduction_seen_r <= 1'b0;
			end
		end
	end

	// current codes caught on the rising edge of the dc limit flag
	// a limit that stays reached does not overwrite the first capture
	always @(posedge MCLK) begin
		if (!RST_N) begin
			dc_q_r                  <= 1'b0;
			led1_captured_current_r <= `FFSE_RST_CODE;
			led2_captured_current_r <= `FFSE_RST_CODE;
		end else begin
			dc_q_r <= dc_limit_reached;
			if (dc_limit_reached & ~dc_q_r) begin
				led1_captured_current_r <= LED1_FLASH_CODE;
				led2_captured_current_r <= LED2_FLASH_CODE;
			end
		end
	end

	// line history; resets to the idle level so no false edge follows reset
	always @(posedge MCLK) begin
		if (!RST_N) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= SCL_IN;
			sda_q_r <= SDA_IN;
		end
	end

	// data line value while driven; open drain only ever pulls low
	always @(posedge MCLK) begin
		if (!RST_N) begin
			sda_out_r <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
		end
	end

	// serial slave: byte shifting, ack, register writes and read-out
	always @(posedge MCLK) begin
		if (!RST_N) begin
			state_r              <= ST_IDLE;
			after_ack_r          <= ST_IDLE;
			ack_on_r             <= 1'b0;
			cnt_r                <= `FFSE_CNT_ZERO;
			rx_r                 <= `FFSE_RST_SHIFT;
			tx_r                 <= `FFSE_RST_BYTE;
			ptr_r                <= `FFSE_RST_BYTE;
			sda_oe_r             <= 1'b0;
			led_channel_enable_r <= `FFSE_RST_ENABLE;
		end else begin
			// start or stop aborts whatever transfer is under way
			if (bus_start) begin
				state_r  <= ST_ADDR;
				cnt_r    <= `FFSE_CNT_ZERO;
				sda_oe_r <= 1'b0;
				ack_on_r <= 1'b0;
			end else if (bus_stop) begin
				state_r  <= ST_IDLE;
				sda_oe_r <= 1'b0;
				ack_on_r <= 1'b0;
			end else begin
				case (state_r)
					// waiting for a start
					ST_IDLE: begin
						sda_oe_r <= 1'b0;
					end
					// eight rising edges fill a byte; the ack follows
					ST_ADDR, ST_REG, ST_WR: begin
						if (scl_rise) begin
							rx_r  <= rx_byte[6:0];
							cnt_r <= cnt_r + `FFSE_CNT_ONE;
							if (cnt_r == `FFSE_CNT_LAST) begin
								cnt_r    <= `FFSE_CNT_ZERO;
								ack_on_r <= 1'b0;
								state_r  <= ST_ACK;
								if (state_r == ST_ADDR) begin
									// another slave's address: stay off the bus
									if (rx_byte[7:1] != DEV_ADDR) begin
										state_r <= ST_IDLE;
									end else if (rx_byte[0]) begin
										// load the first read byte while the ack is sent
										after_ack_r <= ST_RD;
										tx_r        <= rd_mux(ptr_r);
									end else begin
										after_ack_r <= ST_REG;
									end
								end else if (state_r == ST_REG) begin
									// second byte sets the register pointer
									ptr_r       <= rx_byte;
									after_ack_r <= ST_WR;
								end else begin
									after_ack_r <= ST_WR;
									ptr_r       <= ptr_r + `FFSE_PTR_STEP;
									// only the enable register takes data
									// the pointer moves on even when the data is dropped
									if (ptr_r == `FFSE_OFS_ENABLE && en_write_ok) begin
										led_channel_enable_r <= rx_byte;
									end
								end
							end
						end
					end
					// first fall drives the ack, the next one releases it, or before a read puts out the first data bit
					ST_ACK: begin
						if (scl_fall) begin
							if (!ack_on_r) begin
								ack_on_r <= 1'b1;
								sda_oe_r <= 1'b1;
							end else begin
								ack_on_r <= 1'b0;
								state_r  <= after_ack_r;
								if (after_ack_r == ST_RD) begin
									sda_oe_r <= ~tx_r[7];
									tx_r     <= {tx_r[6:0], 1'b0};
									cnt_r    <= `FFSE_CNT_ONE;
								end else begin
									sda_oe_r <= 1'b0;
								end
							end
						end
					end
					// each fall puts the next bit out, msb first
					ST_RD: begin
						if (scl_fall) begin
							// eighth bit done: let go for the host's ack
							if (cnt_r == `FFSE_CNT_BYTE) begin
								sda_oe_r <= 1'b0;
								state_r  <= ST_RACK;
							end else begin
								sda_oe_r <= ~tx_r[7];
								tx_r     <= {tx_r[6:0], 1'b0};
								cnt_r    <= cnt_r + `FFSE_CNT_ONE;
							end
						end
					end
					ST_RACK: begin
						// master ack asks for the next register, nack ends it
						if (scl_rise) begin
							// master ack: advance and load the next register
							if (!SDA_IN) begin
								ptr_r   <= ptr_r + `FFSE_PTR_STEP;
								tx_r    <= rd_mux(ptr_r + `FFSE_PTR_STEP);
								cnt_r   <= `FFSE_CNT_ZERO;
								state_r <= ST_RD;
							end else begin
								state_r <= ST_IDLE;
							end
						end
					end
					// an illegal state falls back to idle
					default: begin
						state_r  <= ST_IDLE;
						sda_oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// outputs straight from flops
	assign SDA_OUT  = sda_out_r;
	assign SDA_OE   = sda_oe_r;
	assign CHAN1_ON = chan1_on;
	assign CHAN2_ON = chan2_on;

endmodule // ffse_regs

`default_nettype wire

// ### verif/ffse_regs_props.sv
// checker for the fault/enable register bank, watching top-level pins only
// assumes the host keeps SCL high and low for two MCLK periods or more
`timescale 1ns/10ps
`default_nettype none
module ffse_regs_props (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic CHAN1_ON,
	input wire logic CHAN2_ON
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// steps of a bus clock fall as the bank samples it
	sequence s_scl_fell;
		$past(SCL_IN, 2) && !$past(SCL_IN);
	endsequence
	sequence s_chan_move;
		$changed({CHAN1_ON, CHAN2_ON});
	endsequence
	property p_no_late2; $rose(CHAN2_ON) |-> !$past(CHAN1_ON); endproperty
	property p_no_late1; $rose(CHAN1_ON) |-> !$past(CHAN2_ON); endproperty
	property p_rst_off; $rose(RST_N) |-> !CHAN1_ON && !CHAN2_ON && !SDA_OE; endproperty
	property p_chan_scl; s_chan_move |-> SCL_IN; endproperty
	property p_oe_rise; $rose(SDA_OE) |-> s_scl_fell; endproperty
	property p_oe_fall; $fell(SDA_OE) |-> s_scl_fell; endproperty
	property p_oe_low_scl; $changed(SDA_OE) |-> !SCL_IN; endproperty
	property p_sda_zero; SDA_OE |-> !SDA_OUT; endproperty
	a_no_late2: assert property (p_no_late2) else $error("chan2 rose over chan1");
	a_no_late1: assert property (p_no_late1) else $error("chan1 rose over chan2");
	a_rst_off: assert property (p_rst_off) else $error("outputs on after reset");
	a_chan_scl: assert property (p_chan_scl) else $error("chan moved off a bit");
	a_oe_rise: assert property (p_oe_rise) else $error("oe rose off a fall");
	a_oe_fall: assert property (p_oe_fall) else $error("oe fell off a fall");
	a_oe_low_scl: assert property (p_oe_low_scl) else $error("oe moved with scl high");
	a_sda_zero: assert property (p_sda_zero) else $error("sda driven high");
endmodule // ffse_regs_props
bind ffse_regs ffse_regs_props u_ffse_regs_props (.MCLK(MCLK), .RST_N(RST_N),
	.SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CHAN1_ON(CHAN1_ON),
	.CHAN2_ON(CHAN2_ON));
`default_nettype wire

// ### verif/ffse_host.sv
// bus master model: byte reads and writes on an open-drain, pulled-up line
// assumes sda_in is the resolved line level; releasing sda means 1
`timescale 1ns/10ps
`default_nettype none
module ffse_host #(
	parameter logic [6:0] ADDR = 7'h2a // arbitrary neutral slave address
) (
	input wire logic mclk,
	input wire logic sda_in,
	output var logic scl,
	output var logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// two cycles per phase keeps the bank's minimum high and low times
	task automatic bitx(input logic b, output logic r);
		sda <= b;
		tick(2);
		scl <= 1'b1;
		tick(2);
		r = sda_in;
		scl <= 1'b0;
		tick(1);
	endtask
	// data is raised before scl so a repeated start never looks like a stop
	task automatic start;
		sda <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(2);
		sda <= 1'b0;
		tick(2);
		scl <= 1'b0;
		tick(1);
	endtask
	task automatic stop;
		sda <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(2);
		sda <= 1'b1;
		tick(2);
	endtask
	task automatic byt(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(m, a);
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start;
		byt({ADDR, 1'b0}, 1'b1, q, a0);
		byt(o, 1'b1, q, a1);
		byt(d, 1'b1, q, a2);
		stop;
		ok = !(a0 | a1 | a2);
	endtask
	// single-byte read ended by a master nack
	task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, an;
		start;
		byt({ADDR, 1'b0}, 1'b1, q, a0);
		byt(o, 1'b1, q, a1);
		start;
		byt({ADDR, 1'b1}, 1'b1, q, a2);
		byt(8'hff, 1'b1, d, an);
		stop;
		ok = !(a0 | a1 | a2);
	endtask
endmodule // ffse_host
`default_nettype wire

// ### verif/ffse_regs_bench.sv
// self-checking bench for the fault/enable register bank
// assumes the host model drives the bus; detectors are driven here
`timescale 1ns/10ps
`default_nettype none
module ffse_regs_bench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] det = 10'h000; // 9 dc en, 8 lowbat en, 7..4 and 2..0 fault bits, 3 unused
	logic fa = 1'b0;
	logic tx = 1'b0;
	logic [5:0] c1 = 6'h00;
	logic [5:0] c2 = 6'h00;
	wire scl, sda_h, sda_oe, sda_out, ch1, ch2;
	wire sda_w = sda_oe ? (sda_h & sda_out) : sda_h; // pulled-up open-drain line
	int n_mismatch = 0;
	int n_tests = 0;
	logic [7:0] wv [10] = '{8'h00, 8'h03, 8'h00, 8'h01, 8'h03, 8'h00, 8'h02, 8'h03, 8'h00, 8'hfd};
	logic [7:0] ev [10] = '{8'h00, 8'h03, 8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h02, 8'h00, 8'hfd};
	initial forever #50 mclk = ~mclk;
	ffse_regs u_ffse_regs (.MCLK(mclk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .OVP_DET(det[7]), .SHORT_DET(det[6]),
		.OVERTEMP_DET(det[5]), .TIMEOUT_DET(det[4]), .FLASH_ACTIVE(fa), .TRANSMITTER_REDUCTION_INPUT_IN(tx),
		.LOWBAT_DET(det[2]), .LOWBAT_DET_EN(det[8]), .IPEAK_DET(det[1]),
		.DC_LIMIT_DET(det[0]), .DC_LIMIT_EN(det[9]), .LED1_FLASH_CODE(c1),
		.LED2_FLASH_CODE(c2), .CHAN1_ON(ch1), .CHAN2_ON(ch2));
	ffse_host u_ffse_host (.mclk(mclk), .sda_in(sda_w), .scl(scl), .sda(sda_h));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rreg(input logic [7:0] o, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_ffse_host.rd(o, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask
	task automatic wreg(input logic [7:0] o, input logic [7:0] d);
		logic ok;
		u_ffse_host.wr(o, d, ok);
		chk({7'h00, ok}, 8'h01); // ignored writes are still acknowledged
	endtask
	task automatic set(input logic [9:0] v);
		@(posedge mclk) det <= v;
		repeat (3) @(posedge mclk);
	endtask
	task automatic t_faults;
		for (int i = 0; i < 8; i++) if (i != 3) begin
			set(10'h300 | (10'h001 << i));
			rreg(8'h0c, 8'h01 << i);
		end
		set(10'h005);
		rreg(8'h0c, 8'h00);
		set(10'h000);
		@(posedge mclk) {fa, tx} <= 2'b11;
		@(posedge mclk) {fa, tx} <= 2'b00;
		rreg(8'h0c, 8'h08);
		@(posedge mclk) fa <= 1'b1;
		@(posedge mclk) fa <= 1'b0;
		rreg(8'h0c, 8'h00);
	endtask
	task automatic t_capture;
		@(posedge mclk) {c1, c2} <= {6'h28, 6'h3c};
		set(10'h200);
		set(10'h201);
		@(posedge mclk) {c1, c2} <= {6'h01, 6'h3f};
		set(10'h000);
		rreg(8'h0d, 8'h28);
		rreg(8'h0e, 8'h3c);
		wreg(8'h0d, 8'hff);
		wreg(8'h0c, 8'hff);
		rreg(8'h0d, 8'h28);
		rreg(8'h0c, 8'h00);
	endtask
	// clear, both together, single channels, and one-sided adds to a running channel, which are dropped
	task automatic t_enable;
		for (int i = 0; i < 10; i++) begin
			wreg(8'h0f, wv[i]);
			rreg(8'h0f, ev[i]);
			chk({6'h00, ch2, ch1}, {6'h00, ev[i][1:0]});
		end
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rreg(8'h0c, 8'h00);
		rreg(8'h0e, 8'h00);
		rreg(8'h0f, 8'h00);
		rreg(8'h05, 8'h00);
		t_faults;
		t_capture;
		t_enable;
		report_and_stop;
	end
endmodule // ffse_regs_bench
`default_nettype wire
